// [hw/qos_consts.svh]
`ifndef QOS_CONSTS_SVH
`define QOS_CONSTS_SVH
// ==========================================
// Sizes
`define QOS_DATA_W       16
`define QOS_NPORTS       8
`define QOS_NQ           4
`define QOS_QDEPTH       16
`define QOS_SEQ_W        7
`define QOS_ADDR_W       12
// ==========================================
// Register offsets
`define QOS_OFF_MODE     12'h000
`define QOS_OFF_WEIGHT   12'h004
`define QOS_OFF_LMAP     12'h008
`define QOS_OFF_PSET     12'h00C
`define QOS_OFF_PPRIO    12'h010
`define QOS_OFF_STATUS   12'h014
// ==========================================
// Reset values and fields
`define QOS_RST_WEIGHT   16'h1248
`define QOS_RST_LMAP     16'h05AF
`define QOS_RST_PPRIO    32'h0000_0000
`define QOS_PSET_EN_BIT  8
`define QOS_PSET_PRIO_LO 9
`define QOS_PSET_PRIO_HI 11
`define QOS_HIGHEST_Q    2'h0
`define QOS_LOWEST_Q     2'h3
`define QOS_UNTAG_LVL    3'h0
`endif

// [hw/qos_pkg.sv]
`default_nettype none
package qos_pkg;
`include "qos_consts.svh"
    typedef enum logic [1:0] {mode_disabled, mode_fcfs, mode_strict, mode_wrr} qos_mode_e;
    typedef logic [`QOS_DATA_W-1:0] data_t;
    typedef struct packed {
        qos_mode_e              mode;
        logic [15:0]            weight;
        logic [15:0]            lmap;
        logic [31:0]            pprio;
        logic [1:0]             wrr_q;
        logic [3:0]             wrr_cnt;
        logic [`QOS_SEQ_W-1:0]  seq;
        logic                   out_valid;
        data_t                  out_data;
        logic [1:0]             out_queue;
    } sched_s;
endpackage
`default_nettype wire

// [hw/egress_qos_queue_scheduler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "qos_consts.svh"

// ==========================================
// Queue FIFO
module qos_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_s;

    fifo_s      s;
    fifo_s      next_s;
    logic [W-1:0] mem [DEPTH];

    // Extra pointer bit tells full from empty
    assign wr_ready = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
    assign rd_valid = (s.wr != s.rd);
    assign rd_data  = mem[s.rd[AW-1:0]];

    always_comb begin
        next_s = s;
        if (wr_valid && wr_ready) begin
            next_s.wr = s.wr + 1'b1;
        end
        if (rd_valid && rd_ready) begin
            next_s.rd = s.rd + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage has no reset to keep it plain RAM
    always_ff @(posedge pclk) begin
        if (wr_valid && wr_ready) begin
            mem[s.wr[AW-1:0]] <= wr_data;
        end
    end
endmodule

// ==========================================
// Overview of operation
// - Four transmit queues, highest to lowest, are drained according to the selected mode.
// - Disabled mode applies no priority: all frames share the lowest queue, sent in order.
// - First-come-first-served mode sends frames in arrival order across all queues.
// - Strict mode never serves a queue while a higher queue holds frames.
// - After reset the mode is weighted round robin with weights 8:4:2:1.
// - Each queue has a weight giving how many frames it sends before service moves down.
// - A tagged frame is queued by looking its tag priority up in the level map.
// - An untagged frame takes its port's static priority, or level 0 if that is disabled, then goes through the same map.
// - The level map assigns each of the eight levels to any of the four queues.
// - After reset levels 0-1 map lowest, 2-3 second-low, 4-5 second-high, 6-7 highest.
// - Each port priority is disabled or a level 0-7, written to a group of ports at once.
module egress_qos_queue_scheduler
    import qos_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`QOS_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [`QOS_DATA_W-1:0]   in_data,
    input  wire logic                     in_tagged,
    input  wire logic [2:0]               in_tag_prio,
    input  wire logic [2:0]               in_port,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [`QOS_DATA_W-1:0]        out_data,
    output logic [1:0]                    out_queue
);
    localparam int EW = `QOS_SEQ_W + `QOS_DATA_W;

    sched_s                 s;
    sched_s                 next_s;
    logic [2:0]             lvl;
    logic [3:0]             port_cfg;
    logic [1:0]             push_q;
    logic                   push;
    logic                   take;
    logic                   sel_ok;
    logic [1:0]             sel_q;
    logic [3:0]             cur_weight;
    logic [`QOS_SEQ_W-1:0]  best_age;
    logic                   wr_en;
    logic                   mapped;
    logic [`QOS_NQ-1:0]     q_wr_valid;
    logic [`QOS_NQ-1:0]     q_wr_ready;
    logic [`QOS_NQ-1:0]     q_rd_valid;
    logic [`QOS_NQ-1:0]     q_rd_ready;
    logic [EW-1:0]          q_rd_data [`QOS_NQ];
    logic [`QOS_SEQ_W-1:0]  age [`QOS_NQ];

    // ==========================================
    // Classification
    assign port_cfg = s.pprio[{in_port, 2'b00} +: 4];
    assign lvl      = in_tagged ? in_tag_prio :
                      (port_cfg[3] ? port_cfg[2:0] : `QOS_UNTAG_LVL);
    assign push_q   = (s.mode == mode_disabled) ? `QOS_LOWEST_Q :
                      s.lmap[{lvl, 1'b0} +: 2];
    assign in_ready = q_wr_ready[push_q];
    assign push     = in_valid && in_ready;

    // ==========================================
    // Queues
    genvar gi;
    generate
        for (gi = 0; gi < `QOS_NQ; gi++) begin : g_q
            assign q_wr_valid[gi] = in_valid && (push_q == 2'(gi));
            assign q_rd_ready[gi] = take && sel_ok && (sel_q == 2'(gi));
            // Stamps wrap, but 64 frames in flight never alias a 7-bit space
            assign age[gi] = s.seq - q_rd_data[gi][EW-1 -: `QOS_SEQ_W];
            qos_fifo #(
                .W     (EW),
                .DEPTH (`QOS_QDEPTH)
            ) u_fifo (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr_valid (q_wr_valid[gi]),
                .wr_ready (q_wr_ready[gi]),
                .wr_data  ({s.seq, in_data}),
                .rd_valid (q_rd_valid[gi]),
                .rd_ready (q_rd_ready[gi]),
                .rd_data  (q_rd_data[gi])
            );
        end
    endgenerate

    // ==========================================
    // Departure selection
    assign take       = !s.out_valid || out_ready;
    assign cur_weight = s.weight[{s.wrr_q, 2'b00} +: 4];

    always_comb begin
        sel_ok   = 1'b0;
        sel_q    = `QOS_HIGHEST_Q;
        best_age = '0;
        unique case (s.mode)
            mode_disabled, mode_fcfs: begin
                for (int i = 0; i < `QOS_NQ; i++) begin
                    if (q_rd_valid[i] && (!sel_ok || age[i] > best_age)) begin
                        sel_ok   = 1'b1;
                        sel_q    = 2'(i);
                        best_age = age[i];
                    end
                end
            end
            mode_strict: begin
                for (int i = `QOS_NQ - 1; i >= 0; i--) begin
                    if (q_rd_valid[i]) begin
                        sel_ok = 1'b1;
                        sel_q  = 2'(i);
                    end
                end
            end
            mode_wrr: begin
                sel_ok = q_rd_valid[s.wrr_q] && (s.wrr_cnt < cur_weight);
                sel_q  = s.wrr_q;
            end
        endcase
    end

    // ==========================================
    // APB slave, zero wait states
    assign wr_en   = psel && penable && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0000_0000;
        unique case (paddr)
            `QOS_OFF_MODE:   prdata = {30'h0000_0000, s.mode};
            `QOS_OFF_WEIGHT: prdata = {16'h0000, s.weight};
            `QOS_OFF_LMAP:   prdata = {16'h0000, s.lmap};
            `QOS_OFF_PSET:   prdata = 32'h0000_0000;
            `QOS_OFF_PPRIO:  prdata = s.pprio;
            `QOS_OFF_STATUS: prdata = {24'h00_0000, ~q_wr_ready, q_rd_valid};
            default:         mapped = 1'b0;
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.seq = s.seq + 1'b1;
        end
        if (take) begin
            next_s.out_valid = sel_ok;
            if (sel_ok) begin
                next_s.out_data  = q_rd_data[sel_q][`QOS_DATA_W-1:0];
                next_s.out_queue = sel_q;
            end
        end
        if (s.mode == mode_wrr) begin
            // Empty or spent queue hands over at once
            if (!q_rd_valid[s.wrr_q] || s.wrr_cnt >= cur_weight) begin
                next_s.wrr_q   = s.wrr_q + 1'b1;
                next_s.wrr_cnt = '0;
            end else if (take) begin
                next_s.wrr_cnt = s.wrr_cnt + 1'b1;
            end
        end else begin
            next_s.wrr_q   = `QOS_HIGHEST_Q;
            next_s.wrr_cnt = '0;
        end
        if (wr_en) begin
            unique case (paddr)
                `QOS_OFF_MODE:   next_s.mode   = qos_mode_e'(pwdata[1:0]);
                `QOS_OFF_WEIGHT: next_s.weight = pwdata[15:0];
                `QOS_OFF_LMAP:   next_s.lmap   = pwdata[15:0];
                `QOS_OFF_PSET: begin
                    for (int p = 0; p < `QOS_NPORTS; p++) begin
                        if (pwdata[p]) begin
                            next_s.pprio[p*4 +: 4] = {pwdata[`QOS_PSET_EN_BIT],
                                pwdata[`QOS_PSET_PRIO_HI:`QOS_PSET_PRIO_LO]};
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s         <= '0;
            s.mode    <= mode_wrr;
            s.weight  <= `QOS_RST_WEIGHT;
            s.lmap    <= `QOS_RST_LMAP;
            s.pprio   <= `QOS_RST_PPRIO;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid = s.out_valid;
    assign out_data  = s.out_data;
    assign out_queue = s.out_queue;

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_disabled_lowest: assert property (
        (s.mode == mode_disabled && push) |-> push_q == `QOS_LOWEST_Q)
        else $error("disabled mode queued above lowest");
    a_fcfs_oldest: assert property (
        (s.mode == mode_fcfs && q_rd_ready[1] && q_rd_valid[0]) |-> age[1] > age[0])
        else $error("fcfs skipped an older frame");
    a_strict_higher_empty: assert property (
        (s.mode == mode_strict && q_rd_ready[2]) |-> !q_rd_valid[0] && !q_rd_valid[1])
        else $error("strict served below a busy queue");
    a_wrr_burst_cap: assert property (
        (s.mode == mode_wrr && |q_rd_ready) |-> q_rd_ready[s.wrr_q] && s.wrr_cnt < cur_weight)
        else $error("round robin overran its weight");
    a_wrr_wrap_top: assert property (
        (s.mode == mode_wrr && s.wrr_q == `QOS_LOWEST_Q && !q_rd_valid[3])
        |=> s.wrr_q == `QOS_HIGHEST_Q)
        else $error("round robin did not wrap to highest");
    a_tag_lookup: assert property (
        (push && in_tagged && s.mode != mode_disabled)
        |-> push_q == s.lmap[{in_tag_prio, 1'b0} +: 2])
        else $error("tagged frame in wrong queue");
    a_untag_lookup: assert property (
        (push && !in_tagged && port_cfg[3] && s.mode != mode_disabled)
        |-> push_q == s.lmap[{port_cfg[2:0], 1'b0} +: 2])
        else $error("untagged frame in wrong queue");
    a_map_write: assert property (
        (wr_en && paddr == `QOS_OFF_LMAP) |=> s.lmap == $past(pwdata[15:0]))
        else $error("level map write lost");
    a_group_prio: assert property (
        (wr_en && paddr == `QOS_OFF_PSET && pwdata[0])
        |=> s.pprio[3:0] == {$past(pwdata[8]), $past(pwdata[11:9])})
        else $error("port priority group write lost");
    a_out_hold: assert property (
        (s.out_valid && !out_ready) |=> s.out_valid && $stable(s.out_data))
        else $error("output dropped while stalled");

    c_wrr_turn: cover property (s.mode == mode_wrr && q_rd_ready[0] ##2 q_rd_ready[1]);
    c_strict_pop: cover property (s.mode == mode_strict && q_rd_ready[3]);
    c_fcfs_pop: cover property (s.mode == mode_fcfs && q_rd_ready[2]);
    c_queue_full: cover property (!q_wr_ready[0]);
endmodule
`default_nettype wire

// [dv/qos_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Egress transmitter model
module qos_sink (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [15:0] out_data,
    input  wire logic [1:0]  out_queue,
    output logic             out_ready
);
    logic [17:0] got[$];
    // Ready is registered, so a stall lands one cycle late like a busy MAC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= ~stall;
        end
    end
    always @(posedge pclk) begin
        if (out_valid && out_ready) got.push_back({out_queue, out_data});
    end
endmodule
`default_nettype wire

// [dv/egress_qos_queue_scheduler_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "qos_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module egress_qos_queue_scheduler_tb_top;
    import qos_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid;
    logic        in_ready;
    logic [15:0] in_data;
    logic        in_tagged;
    logic [2:0]  in_tag_prio;
    logic [2:0]  in_port;
    logic        out_valid;
    logic        out_ready;
    logic [15:0] out_data;
    logic [1:0]  out_queue;
    logic        stall;
    logic [31:0] rd;
    logic        err;
    logic [17:0] f;
    int          n_errors;
    int          check_count;
    int          cyc;
    int          n;
    int          m;
    int          wrr_d[7] = '{0, 1, 2, 4, 3, 5, 6};
    egress_qos_queue_scheduler egress_qos_queue_scheduler_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_tagged(in_tagged),
        .in_tag_prio(in_tag_prio), .in_port(in_port), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_queue(out_queue));
    qos_sink qos_sink_i (.pclk(pclk), .presetn(presetn), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_queue(out_queue), .out_ready(out_ready));
    always #25 pclk = ~pclk;
    // ==========================================
    // Run control
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            print_verdict();
        end
    end
    // ==========================================
    // Bus and stream tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends once pready is high, and the slave ties pready high, so after one cycle
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
        `CHK("pslverr", 1'b0, err)
    endtask
    // Ready is combinational on the fields, so look at it mid-cycle
    task automatic push(input logic t, input logic [2:0] p, input logic [2:0] pt,
                        input logic [15:0] d);
        @(posedge pclk);
        in_valid <= 1'b1;
        in_tagged <= t;
        in_tag_prio <= p;
        in_port <= pt;
        in_data <= d;
        do begin
            @(negedge pclk);
        end while (in_ready !== 1'b1);
        @(posedge pclk);
        in_valid <= 1'b0;
    endtask
    task automatic expect_out(input logic [1:0] q, input logic [15:0] d);
        int k;
        k = 0;
        while (qos_sink_i.got.size() == 0 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        // Missing frame stays unknown so both compares trip
        f = 'x;
        if (qos_sink_i.got.size() > 0) f = qos_sink_i.got.pop_front();
        `CHK("out_queue", q, f[17:16])
        `CHK("out_data", d, f[15:0])
    endtask
    // First frame parks in the output stage, the rest queue up behind it
    task automatic load(input logic [15:0] b);
        stall <= 1'b1;
        push(1'b1, 3'h7, 3'h0, b);
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 4; i++) push(1'b1, 3'(2 * i), 3'h0, b + 16'(i + 1));
    endtask
    // ==========================================
    // Tests
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        in_valid = 1'b0;
        in_data = 16'h0;
        in_tagged = 1'b0;
        in_tag_prio = 3'h0;
        in_port = 3'h0;
        stall = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`QOS_OFF_MODE, 32'(mode_wrr), "mode");
        rd_chk(`QOS_OFF_WEIGHT, 32'h1248, "weight");
        rd_chk(`QOS_OFF_LMAP, 32'h05AF, "lmap");
        rd_chk(`QOS_OFF_PPRIO, 32'h0, "pprio");
        apb(1'b0, 12'h100, 32'h0);
        `CHK("pslverr", 1'b1, err)
        $display("reset test done");
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_strict));
        load(16'hA0);
        stall <= 1'b0;
        expect_out(2'h0, 16'hA0);
        for (int i = 3; i >= 0; i--) expect_out(2'h3 - 2'(i), 16'hA1 + 16'(i));
        $display("strict test done");
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_fcfs));
        load(16'hB0);
        stall <= 1'b0;
        expect_out(2'h0, 16'hB0);
        for (int i = 0; i < 4; i++) expect_out(2'h3 - 2'(i), 16'hB1 + 16'(i));
        $display("fcfs test done");
        apb(1'b1, `QOS_OFF_PSET, 32'h0000_0B06);
        rd_chk(`QOS_OFF_PPRIO, 32'h0000_0DD0, "pprio");
        push(1'b0, 3'h0, 3'h1, 16'hC0);
        expect_out(2'h1, 16'hC0);
        push(1'b0, 3'h7, 3'h3, 16'hC1);
        expect_out(`QOS_LOWEST_Q, 16'hC1);
        apb(1'b1, `QOS_OFF_PSET, 32'h0000_0006);
        rd_chk(`QOS_OFF_PPRIO, 32'h0, "pprio");
        apb(1'b1, `QOS_OFF_LMAP, 32'h0000_05AC);
        rd_chk(`QOS_OFF_LMAP, 32'h05AC, "lmap");
        push(1'b1, 3'h0, 3'h0, 16'hC2);
        expect_out(`QOS_HIGHEST_Q, 16'hC2);
        $display("map test done");
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_strict));
        stall <= 1'b1;
        push(1'b1, 3'h7, 3'h0, 16'hD0);
        repeat (3) @(posedge pclk);
        for (int i = 1; i < 7; i++) push(1'b1, (i < 4) ? 3'h6 : 3'h4, 3'h0, 16'hD0 + 16'(i));
        apb(1'b1, `QOS_OFF_WEIGHT, 32'h1112);
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_wrr));
        stall <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            expect_out((wrr_d[i] < 4) ? 2'h0 : 2'h1, 16'hD0 + 16'(wrr_d[i]));
        end
        $display("wrr test done");
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_disabled));
        push(1'b1, 3'h7, 3'h0, 16'hE0);
        expect_out(`QOS_LOWEST_Q, 16'hE0);
        $display("disabled test done");
        apb(1'b1, `QOS_OFF_MODE, 32'(mode_strict));
        stall <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge pclk);
            if (in_ready !== 1'b1) break;
            push(1'b1, 3'h6, 3'h0, 16'(n));
        end
        `CHK("in_ready", 1'b0, in_ready)
        rd_chk(`QOS_OFF_STATUS, 32'h11, "status");
        stall <= 1'b0;
        m = 0;
        while (qos_sink_i.got.size() < n && m < 200) begin
            @(posedge pclk);
            m++;
        end
        `CHK("drained", n, qos_sink_i.got.size())
        for (int i = 0; i < n; i++) expect_out(2'h0, 16'(i));
        rd_chk(`QOS_OFF_STATUS, 32'h0, "status");
        $display("fill test done");
        print_verdict();
    end
endmodule
`default_nettype wire
